/* File: design/sequencer_defs.svh */
// Constants of the microprogram sequencer
`ifndef SEQUENCER_DEFS_SVH
`define SEQUENCER_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SEQ_CLK_PERIOD_NS 40
`define SEQ_INSTR_CYCLE_NS 200
`define SEQ_PHASE_WIDTH_NS 50
`define SEQ_INSTR_CYCLES (`SEQ_INSTR_CYCLE_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_PHASE_CYCLES (`SEQ_PHASE_WIDTH_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_SLOT_COUNT 5

// ----------------------------------------------------------------
// Control store geometry
// ----------------------------------------------------------------
`define SEQ_STORE_WORDS 1536
`define SEQ_FIELD_WORDS 256
`define SEQ_FIELD_COUNT 6
`define SEQ_FIELD_LAST 3'h5
`define SEQ_PAD_WORDS 16

// ----------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------
`define SEQ_OP_HI 7
`define SEQ_OP_LO 6
`define SEQ_SEL_HI 5
`define SEQ_SEL_LO 2
`define SEQ_CTRL_ONE 1
`define SEQ_CTRL_ZERO 0

// ----------------------------------------------------------------
// Instruction classes
// ----------------------------------------------------------------
`define SEQ_CLASS_STROBE 2'h0
`define SEQ_CLASS_CBR 2'h1
`define SEQ_CLASS_PAD_JMP 2'h2
`define SEQ_CLASS_WBR 2'h3

// ----------------------------------------------------------------
// Strobe select codes with internal targets
// ----------------------------------------------------------------
`define SEQ_IFACE_FLAGS 8
`define SEQ_STB_COUNTER 4'hc
`define SEQ_STB_SHIFTER 4'hd
`define SEQ_STB_PAD_WRITE 4'he

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEQ_PC_RESET 8'h00
`define SEQ_FIELD_RESET 3'h0
`define SEQ_BYTE_RESET 8'h00

`endif

/* File: design/sequencer_pkg.sv */
// Types of the microprogram sequencer
package sequencer_pkg;

    // ----------------------------------------------------------------
    // Instruction cycle slots, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        SLOT_FETCH   = 5'h01,
        SLOT_CAPTURE = 5'h02,
        SLOT_PHASE_A = 5'h04,
        SLOT_GAP     = 5'h08,
        SLOT_PHASE_B = 5'h10
    } slot_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        en;
        logic [10:0] addr;
        logic [7:0]  data;
    } store_load_t;

    typedef struct packed {
        logic fetch_advance_strobe;
        logic counter_load_enable;
        logic wait_counter_clock;
        logic pad_addr_clock;
        logic pad_write_strobe;
    } seq_strobes_t;

endpackage

/* File: design/control_store.sv */
// Control store memory with registered read
module control_store #(
    parameter int DEPTH = 1536,
    parameter int WIDTH = 8,
    parameter int ADDR_W = 11
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin
            $error("control_store: depth does not fit address width");
        end
    end

    always_ff @(posedge clock) begin
        if (wr_en && int'(wr_addr) < DEPTH) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (int'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule // control_store

/* File: design/scratch_pad.sv */
// Scratch pad memory with registered read
module scratch_pad #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2) begin
            $error("scratch_pad: depth too small");
        end
    end

    // Write while strobed, read otherwise
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end else begin
            rd_data <= mem[addr];
        end
    end
endmodule // scratch_pad

/* File: design/microprogram_sequencer.sv */
// Microprogram sequencer top
//
// Operation
// - Control store holds 1536 eight-bit words of microprogram.
// - Store splits into six fields of 256 words, addressed by program counter.
// - Program counter updates once per 200 ns instruction cycle.
// - Fetch/advance strobe captures addressed word and advances the counter.
// - Top two bits select strobe, branch, pad-open or jump, wait branch.
// - Open-pad select field addresses one of sixteen pad words.
// - Field counter increments on field crossing, loads 0..5 on jump.
// - Low bits are control; bit one sets or clears interface flags.
// - Counter increments after strobe, pad-open and untaken branches.
// - Jump or taken branch loads eight-bit address from next word or pad.
// - Inhibit flag suppresses decode while operand words are fetched.
// - Strobe at first phase pulses the output numbered by select field.
// - Branch condition multiplexer uses select field on every branch.
// - Condition matching control bit one enables the counter load strobe; fetch strobe fires once per instruction cycle.
// - Wait-branch counter clock asserts on each wait branch.
// - Pad address register captures select field on open-pad clock.
// - Pad stores sixteen bytes, writes shifter data when strobed.
// - Selector takes pad data when control bit zero set, else store.
// - Selector feeds program counter and general counter.
// - General counter loads selector when bit one clear, else increments.
// - Shifter: 00 shift zero, 01 load counter, 10 shift one, 11 data.
// - Two single-slot phases from a recirculating ring, first before second.
`include "sequencer_defs.svh"

module microprogram_sequencer #(
    parameter int STORE_WORDS = `SEQ_STORE_WORDS,
    parameter int PAD_WORDS = `SEQ_PAD_WORDS
) (
    input wire logic clock,
    input wire logic rst,
    input sequencer_pkg::store_load_t store_load,
    input wire logic [15:0] cond_lines,
    input wire logic sep_data,
    output logic [7:0] program_counter,
    output logic [2:0] field_q,
    output logic decode_inhibit,
    output logic timing_phase_a,
    output logic timing_phase_b,
    output logic [15:0] strobe_out,
    output sequencer_pkg::seq_strobes_t strobes,
    output logic [`SEQ_IFACE_FLAGS-1:0] iface_flags,
    output logic [7:0] gen_count,
    output logic [7:0] shifter,
    output logic [3:0] pad_addr
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    initial begin
        if (STORE_WORDS != `SEQ_FIELD_WORDS * `SEQ_FIELD_COUNT) begin
            $error("microprogram_sequencer: store must be six fields of 256");
        end
        if (PAD_WORDS != `SEQ_PAD_WORDS) begin
            $error("microprogram_sequencer: pad must hold sixteen words");
        end
        if (`SEQ_INSTR_CYCLES != `SEQ_SLOT_COUNT || `SEQ_PHASE_CYCLES != 1) begin
            $error("microprogram_sequencer: clock rate does not fit the ring");
        end
    end

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [2:0] next_field(input logic [2:0] f);
        next_field = (f >= `SEQ_FIELD_LAST) ? `SEQ_FIELD_RESET : f + 3'h1;
    endfunction

    function automatic logic [10:0] store_addr(input logic [2:0] f, input logic [7:0] a);
        store_addr = {f, a};
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [15:0] cond_meta_q;
    logic [15:0] cond_sync_q;
    logic sep_meta_q;
    logic sep_sync_q;

    always_ff @(posedge clock) begin
        cond_meta_q <= cond_lines;
        cond_sync_q <= cond_meta_q;
        sep_meta_q <= sep_data;
        sep_sync_q <= sep_meta_q;
    end

    // ----------------------------------------------------------------
    // Timing ring
    // ----------------------------------------------------------------
    sequencer_pkg::slot_t slot_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            slot_q <= sequencer_pkg::SLOT_FETCH;
        end else begin
            unique case (slot_q)
                sequencer_pkg::SLOT_FETCH: slot_q <= sequencer_pkg::SLOT_CAPTURE;
                sequencer_pkg::SLOT_CAPTURE: slot_q <= sequencer_pkg::SLOT_PHASE_A;
                sequencer_pkg::SLOT_PHASE_A: slot_q <= sequencer_pkg::SLOT_GAP;
                sequencer_pkg::SLOT_GAP: slot_q <= sequencer_pkg::SLOT_PHASE_B;
                sequencer_pkg::SLOT_PHASE_B: slot_q <= sequencer_pkg::SLOT_FETCH;
                default: slot_q <= sequencer_pkg::SLOT_FETCH;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            timing_phase_a <= 1'b0;
            timing_phase_b <= 1'b0;
        end else begin
            timing_phase_a <= (slot_q == sequencer_pkg::SLOT_CAPTURE);
            timing_phase_b <= (slot_q == sequencer_pkg::SLOT_GAP);
        end
    end

    wire capture = (slot_q == sequencer_pkg::SLOT_CAPTURE);
    wire phase_a = (slot_q == sequencer_pkg::SLOT_PHASE_A);

    // ----------------------------------------------------------------
    // Memories
    // ----------------------------------------------------------------
    logic [7:0] store_word;
    logic [7:0] pad_word;
    logic pad_write;

    control_store #(
        .DEPTH(STORE_WORDS),
        .WIDTH(8),
        .ADDR_W(11)
    ) u_store (
        .clock(clock),
        .wr_en(store_load.en),
        .wr_addr(store_load.addr),
        .wr_data(store_load.data),
        .rd_addr(store_addr(field_q, program_counter)),
        .rd_data(store_word)
    );

    scratch_pad #(
        .DEPTH(PAD_WORDS),
        .WIDTH(8)
    ) u_pad (
        .clock(clock),
        .wr_en(pad_write),
        .addr(pad_addr),
        .wr_data(shifter),
        .rd_data(pad_word)
    );

    // ----------------------------------------------------------------
    // Memory buffer and decode
    // ----------------------------------------------------------------
    logic [7:0] mb_q;
    logic exec_valid_q;
    logic load_pending_q;
    logic count_pending_q;
    logic [2:0] field_pending_q;
    logic jump_pending_q;

    wire [1:0] op = mb_q[`SEQ_OP_HI:`SEQ_OP_LO];
    wire [3:0] sel = mb_q[`SEQ_SEL_HI:`SEQ_SEL_LO];
    wire ctrl_bit_one = mb_q[`SEQ_CTRL_ONE];
    wire ctrl_bit_zero = mb_q[`SEQ_CTRL_ZERO];
    wire strobe_op = exec_valid_q && op == `SEQ_CLASS_STROBE;
    wire cond_branch_op = exec_valid_q && op == `SEQ_CLASS_CBR;
    wire open_pad_op = exec_valid_q && op == `SEQ_CLASS_PAD_JMP && !ctrl_bit_one;
    wire jump_op = exec_valid_q && op == `SEQ_CLASS_PAD_JMP && ctrl_bit_one;
    wire wait_branch_op = exec_valid_q && op == `SEQ_CLASS_WBR;
    wire any_branch = cond_branch_op || wait_branch_op;
    wire cond_match = cond_sync_q[sel] == ctrl_bit_one;
    wire count_strobe = strobe_op && sel == `SEQ_STB_COUNTER;
    wire count_load = count_strobe && !ctrl_bit_one;
    wire [7:0] selector = ctrl_bit_zero ? pad_word : store_word;

    always_ff @(posedge clock) begin
        if (rst) begin
            mb_q <= `SEQ_BYTE_RESET;
            exec_valid_q <= 1'b0;
        end else if (capture) begin
            if (!decode_inhibit) begin
                mb_q <= store_word;
                exec_valid_q <= 1'b1;
            end else begin
                exec_valid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Decode inhibit and pending operand actions
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            decode_inhibit <= 1'b0;
            load_pending_q <= 1'b0;
            count_pending_q <= 1'b0;
            jump_pending_q <= 1'b0;
            field_pending_q <= `SEQ_FIELD_RESET;
        end else if (phase_a) begin
            if (any_branch || jump_op || count_load) begin
                decode_inhibit <= 1'b1;
            end
            load_pending_q <= jump_op || (any_branch && cond_match);
            count_pending_q <= count_load;
            jump_pending_q <= jump_op;
            field_pending_q <= sel[2:0];
        end else if (capture && decode_inhibit) begin
            decode_inhibit <= 1'b0;
            load_pending_q <= 1'b0;
            count_pending_q <= 1'b0;
            jump_pending_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Program counter and field counter
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            program_counter <= `SEQ_PC_RESET;
        end else if (capture) begin
            if (decode_inhibit && load_pending_q) begin
                program_counter <= selector;
            end else begin
                program_counter <= program_counter + 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            field_q <= `SEQ_FIELD_RESET;
        end else if (capture) begin
            if (decode_inhibit && jump_pending_q) begin
                if (field_pending_q <= `SEQ_FIELD_LAST) begin
                    field_q <= field_pending_q;
                end
            end else if (!(decode_inhibit && load_pending_q) && program_counter == 8'hff) begin
                field_q <= next_field(field_q);
            end
        end
    end

    // ----------------------------------------------------------------
    // Strobe outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            strobe_out <= 16'h0000;
        end else if (phase_a && strobe_op) begin
            strobe_out <= 16'h0001 << sel;
        end else begin
            strobe_out <= 16'h0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            strobes <= '0;
        end else begin
            strobes.fetch_advance_strobe <= capture;
            strobes.counter_load_enable <= phase_a && (jump_op || (any_branch && cond_match));
            strobes.wait_counter_clock <= phase_a && wait_branch_op;
            strobes.pad_addr_clock <= phase_a && open_pad_op;
            strobes.pad_write_strobe <= phase_a && strobe_op && sel == `SEQ_STB_PAD_WRITE;
        end
    end

    assign pad_write = strobes.pad_write_strobe;

    // ----------------------------------------------------------------
    // Interface flags
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            iface_flags <= '0;
        end else if (phase_a && strobe_op && int'(sel) < `SEQ_IFACE_FLAGS) begin
            iface_flags[sel[2:0]] <= ctrl_bit_one;
        end
    end

    // ----------------------------------------------------------------
    // Scratch pad address register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            pad_addr <= 4'h0;
        end else if (phase_a && open_pad_op) begin
            pad_addr <= sel;
        end
    end

    // ----------------------------------------------------------------
    // General counter
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            gen_count <= `SEQ_BYTE_RESET;
        end else if (capture && decode_inhibit && count_pending_q) begin
            gen_count <= selector;
        end else if (phase_a && ((count_strobe && ctrl_bit_one) || wait_branch_op)) begin
            gen_count <= gen_count + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Shift register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            shifter <= `SEQ_BYTE_RESET;
        end else if (phase_a && strobe_op && sel == `SEQ_STB_SHIFTER) begin
            unique case ({ctrl_bit_one, ctrl_bit_zero})
                2'h0: shifter <= {shifter[6:0], 1'b0};
                2'h1: shifter <= gen_count;
                2'h2: shifter <= {shifter[6:0], 1'b1};
                2'h3: shifter <= {shifter[6:0], sep_sync_q};
            endcase
        end
    end

endmodule // microprogram_sequencer

/* File: test/sequencer_monitor.sv */
// Port checker of the microprogram sequencer
module sequencer_monitor #(
    parameter int STORE_WORDS = 1536,
    parameter int PAD_WORDS = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] program_counter,
    input wire logic [2:0] field_q,
    input wire logic decode_inhibit,
    input wire logic timing_phase_a,
    input wire logic timing_phase_b,
    input wire logic [15:0] strobe_out,
    input wire sequencer_pkg::seq_strobes_t strobes
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Properties
    // --------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_phase_period;
        timing_phase_a |=> !timing_phase_a [*4] ##1 timing_phase_a;
    endproperty
    a_phase_period: assert property (p_phase_period) else $error("phase a period wrong");
    property p_phase_order;
        timing_phase_a |-> !timing_phase_b ##2 timing_phase_b;
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase b not after a");
    property p_fetch_phase;
        strobes.fetch_advance_strobe |-> timing_phase_a;
    endproperty
    a_fetch_phase: assert property (p_fetch_phase) else $error("fetch strobe off phase");
    property p_pc_moment;
        !timing_phase_a |-> $stable(program_counter) && $stable(field_q);
    endproperty
    a_pc_moment: assert property (p_pc_moment) else $error("counter moved off cycle");
    property p_strobe_onehot;
        $onehot0(strobe_out);
    endproperty
    a_strobe_onehot: assert property (p_strobe_onehot) else $error("strobe not one hot");
    property p_strobe_time;
        (|strobe_out) |-> $past(timing_phase_a);
    endproperty
    a_strobe_time: assert property (p_strobe_time) else $error("strobe off phase");
    property p_field_range;
        field_q <= 3'h5;
    endproperty
    a_field_range: assert property (p_field_range) else $error("field out of range");
    property p_load_inhibit;
        strobes.counter_load_enable |-> decode_inhibit ##[1:5] !decode_inhibit;
    endproperty
    a_load_inhibit: assert property (p_load_inhibit) else $error("inhibit wrong on load");
    property p_wait_clock;
        strobes.wait_counter_clock |-> $past(timing_phase_a);
    endproperty
    a_wait_clock: assert property (p_wait_clock) else $error("wait clock off phase");
    property p_pad_clock;
        strobes.pad_addr_clock |-> $past(timing_phase_a);
    endproperty
    a_pad_clock: assert property (p_pad_clock) else $error("pad clock off phase");
    property p_reset_clear;
        $fell(rst) |-> program_counter == 8'h00 && field_q == 3'h0 && !decode_inhibit;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state");
    c_load: cover property (strobes.counter_load_enable);
    c_wait: cover property (strobes.wait_counter_clock);
    c_pad: cover property (strobes.pad_addr_clock);
    c_flag7: cover property (strobe_out[7]);
endmodule // sequencer_monitor

bind microprogram_sequencer sequencer_monitor #(
    .STORE_WORDS(STORE_WORDS),
    .PAD_WORDS(PAD_WORDS)
) mon (
    .clock(clock),
    .rst(rst),
    .program_counter(program_counter),
    .field_q(field_q),
    .decode_inhibit(decode_inhibit),
    .timing_phase_a(timing_phase_a),
    .timing_phase_b(timing_phase_b),
    .strobe_out(strobe_out),
    .strobes(strobes)
);

/* File: test/far_side_model.sv */
// Model of the host logic and read electronics
module far_side_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] cond_pattern,
    output logic [15:0] cond_lines,
    output logic sep_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Condition lines follow the pattern, read data toggles
    always @(posedge clock) begin
        cond_lines <= cond_pattern;
        sep_data <= rst ? 1'b0 : ~sep_data;
    end
endmodule // far_side_model

/* File: test/test_microprogram_sequencer.sv */
// Self-checking bench of the microprogram sequencer
module test_microprogram_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(got, want) begin compares++; if ((got) !== (want)) begin n_errors++; \
        $display("BAD t=%0t %h vs %h", $time, got, want); end end
    typedef struct packed {
        logic [7:0] pc;
        logic [2:0] fld;
        logic [4:0] s;
        logic c1;
        logic ld;
        logic wb;
    } exp_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    sequencer_pkg::store_load_t store_load = '0;
    logic [15:0] cond_pattern = 16'h0000;
    logic [15:0] cond_lines;
    logic sep_data;
    logic [7:0] program_counter;
    logic [2:0] field_q;
    logic decode_inhibit;
    logic timing_phase_a;
    logic timing_phase_b;
    logic [15:0] strobe_out;
    sequencer_pkg::seq_strobes_t strobes;
    logic [7:0] iface_flags;
    logic [7:0] gen_count;
    logic [7:0] shifter;
    logic [3:0] pad_addr;
    int n_errors = 0;
    int compares = 0;
    exp_t exp_q[$];
    logic [7:0] flags_e;

    always #20 clock = ~clock;

    far_side_model far (.clock(clock), .rst(rst), .cond_pattern(cond_pattern),
        .cond_lines(cond_lines), .sep_data(sep_data));
    microprogram_sequencer uut (.clock(clock), .rst(rst), .store_load(store_load),
        .cond_lines(cond_lines), .sep_data(sep_data), .program_counter(program_counter),
        .field_q(field_q), .decode_inhibit(decode_inhibit), .timing_phase_a(timing_phase_a),
        .timing_phase_b(timing_phase_b), .strobe_out(strobe_out), .strobes(strobes),
        .iface_flags(iface_flags), .gen_count(gen_count), .shifter(shifter),
        .pad_addr(pad_addr));

    // --------
    // Helpers
    // --------
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic put(input int a, input logic [7:0] d);
        @(posedge clock);
        store_load <= {1'b1, a[10:0], d};
    endtask
    function automatic logic [7:0] op(input logic [1:0] c, input logic [3:0] sel,
        input logic c1);
        return {c, sel, c1, 1'b0};
    endfunction
    function automatic exp_t ex(input int pc, input int f, input int s, input logic c1,
        input logic ld, input logic wb);
        return {pc[7:0], f[2:0], s[4:0], c1, ld, wb};
    endfunction
    task automatic wait_phase();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (timing_phase_a !== 1'b1 && n < 12);
        if (timing_phase_a !== 1'b1) begin
            n_errors++;
            print_verdict();
        end
    endtask

    // --------
    // One program run
    // --------
    task automatic run_round(input int r);
        logic [7:0] t;
        logic [7:0] u;
        logic [7:0] v;
        logic [15:0] cp;
        logic [3:0] k;
        logic [3:0] p;
        logic c;
        logic cb;
        exp_t e;
        t = 8'($urandom_range(100));
        u = 8'($urandom_range(200, 120));
        v = 8'($urandom);
        k = 4'($urandom);
        p = 4'($urandom);
        cp = 16'($urandom);
        cb = cp[k];
        exp_q.delete();
        flags_e = 8'h00;
        @(posedge clock);
        rst <= 1'b1;
        cond_pattern <= cp;
        for (int i = 0; i < 8; i++) begin
            c = 1'($urandom);
            put(i, op(2'h0, 4'(i), c));
            exp_q.push_back(ex(i + 1, 0, i, c, 0, 0));
        end
        put(8, op(2'h0, 4'hc, 1'b1));
        exp_q.push_back(ex(9, 0, 12, 1, 0, 0));
        put(9, op(2'h2, p, 1'b0));
        exp_q.push_back(ex(10, 0, 16, 0, 0, 0));
        put(10, op(2'h2, 4'h5, 1'b1));
        put(11, t);
        exp_q.push_back(ex(11, 0, 16, 0, 1, 0));
        exp_q.push_back(ex(t, 5, 16, 0, 0, 0));
        put(1280 + t, op(2'h1, k, cb));
        put(1281 + t, u);
        exp_q.push_back(ex(t + 1, 5, 16, 0, 1, 0));
        exp_q.push_back(ex(u, 5, 16, 0, 0, 0));
        put(1280 + u, op(2'h1, k, ~cb));
        put(1281 + u, 8'h00);
        exp_q.push_back(ex(u + 1, 5, 16, 0, 0, 0));
        exp_q.push_back(ex(u + 2, 5, 16, 0, 0, 0));
        put(1282 + u, op(2'h3, k, cb));
        put(1283 + u, v);
        exp_q.push_back(ex(u + 3, 5, 16, 0, 1, 1));
        exp_q.push_back(ex(v, 5, 16, 0, 0, 0));
        @(posedge clock);
        store_load <= '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        `CHK({program_counter, field_q, decode_inhibit, iface_flags, gen_count, shifter, pad_addr}, 40'h0)
        foreach (exp_q[i]) begin
            e = exp_q[i];
            wait_phase();
            `CHK(program_counter, e.pc)
            `CHK(field_q, e.fld)
            `CHK(strobes.fetch_advance_strobe, 1'b1)
            @(posedge clock);
            #1;
            `CHK(strobe_out, (e.s < 16) ? 16'h1 << e.s : 16'h0)
            `CHK(strobes.counter_load_enable, e.ld)
            `CHK(strobes.wait_counter_clock, e.wb)
            if (e.s < 8) begin
                flags_e[e.s] = e.c1;
            end
            @(posedge clock);
            #1;
            `CHK(iface_flags, flags_e)
        end
        `CHK(pad_addr, p)
        `CHK(gen_count, 8'h02)
        $display("round %0d done", r);
    endtask

    initial begin
        void'($urandom(98));
        for (int r = 0; r < 4; r++) begin
            run_round(r);
        end
        print_verdict();
    end
endmodule // test_microprogram_sequencer
